// File: rtl/icsr_regs.sv
// Interrupt controller control and status registers with an APB slave port.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
module icsr_regs (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources.
  input wire logic [icsr_pkg::NUM_VEC-1:0] periph_irq,
  input wire logic [icsr_pkg::NUM_EXT-1:0] ext_int_pin,
  input wire logic trap_overflow,
  input wire logic trap_addr_err,
  input wire logic trap_stack_err,
  input wire logic trap_osc_fail,
  // Processor core side.
  input wire logic core_ack,
  input wire logic core_trap_enter,
  input wire logic core_return,
  input wire logic [3:0] core_return_level,
  input wire logic timed_disable_in,
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [2:0] irq_level,
  output logic alt_vector_sel,
  output logic [3:0] cpu_level_out
);
  import icsr_pkg::*;

  logic [NUM_VEC-1:0] flag_reg;
  logic [NUM_VEC-1:0] enable_reg;
  logic [2:0] level_reg [0:NUM_VEC-1];
  logic [2:0] cpu_level_reg;
  logic level_msb_reg;
  logic nest_disable_reg;
  logic ovf_flag_reg;
  logic addr_err_flag_reg;
  logic stk_err_flag_reg;
  logic osc_fail_flag_reg;
  logic [NUM_EXT-1:0] edge_pol_reg;
  logic [NUM_EXT-1:0] ext_s1_reg;
  logic [NUM_EXT-1:0] ext_s2_reg;
  logic [NUM_EXT-1:0] ext_s3_reg;
  logic [NUM_EXT-1:0] ext_level_reg;
  logic [NUM_EXT-1:0] ext_event;
  logic tdis_s1_reg;
  logic tdis_s2_reg;
  logic [31:0] rd_word;
  logic rd_err;
  logic sel_sr;
  logic sel_core;
  logic sel_gc1;
  logic sel_gc2;
  logic sel_flag;
  logic sel_en;
  logic sel_lvl;
  logic [9:0] widx;
  logic wr_en;
  logic [2:0] best_lvl;
  logic [6:0] best_vec;
  logic best_found;

  // Word offset of an address from a region base.
  function automatic logic [9:0] word_off(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[11:2];
  endfunction

  // True when a word-aligned address falls in a region of the given number of words.
  function automatic logic in_region(input logic [11:0] a, input logic [11:0] base,
                                     input int words);
    return (a >= base) && (word_off(a, base) < 10'(words)) && (a[1:0] == 2'h0);
  endfunction

  // Address decode.
  always_comb begin
    sel_sr = 1'b0;
    sel_core = 1'b0;
    sel_gc1 = 1'b0;
    sel_gc2 = 1'b0;
    sel_flag = 1'b0;
    sel_en = 1'b0;
    sel_lvl = 1'b0;
    widx = 10'h000;
    if (paddr == ADDR_CPU_STATUS) begin
      sel_sr = 1'b1;
    end else if (paddr == ADDR_CORE_CONTROL) begin
      sel_core = 1'b1;
    end else if (paddr == ADDR_GCTRL1) begin
      sel_gc1 = 1'b1;
    end else if (paddr == ADDR_GCTRL2) begin
      sel_gc2 = 1'b1;
    end else if (in_region(paddr, ADDR_FLAG_BASE, NUM_FLAG_REGS)) begin
      sel_flag = 1'b1;
      widx = word_off(paddr, ADDR_FLAG_BASE);
    end else if (in_region(paddr, ADDR_ENABLE_BASE, NUM_FLAG_REGS)) begin
      sel_en = 1'b1;
      widx = word_off(paddr, ADDR_ENABLE_BASE);
    end else if (in_region(paddr, ADDR_LEVEL_BASE, NUM_LVL_REGS)) begin
      sel_lvl = 1'b1;
      widx = word_off(paddr, ADDR_LEVEL_BASE);
    end
  end

  // Read data; bits beyond the implemented vectors stay zero.
  always_comb begin
    int v;
    v = 0;
    rd_word = WORD_ZERO;
    rd_err = 1'b0;
    if (sel_sr) begin
      rd_word[CPU_LVL_LSB +: 3] = cpu_level_reg;
    end else if (sel_core) begin
      rd_word[LEVEL_MSB_BIT] = level_msb_reg;
    end else if (sel_gc1) begin
      rd_word[NEST_DIS_BIT] = nest_disable_reg;
      rd_word[OVF_BIT] = ovf_flag_reg;
      rd_word[ADDR_ERR_BIT] = addr_err_flag_reg;
      rd_word[STK_ERR_BIT] = stk_err_flag_reg;
      rd_word[OSC_FAIL_BIT] = osc_fail_flag_reg;
    end else if (sel_gc2) begin
      rd_word[ALT_VEC_BIT] = alt_vector_sel;
      rd_word[TIMED_DIS_BIT] = tdis_s2_reg;
      rd_word[EDGE_POL_LSB +: NUM_EXT] = edge_pol_reg;
    end else if (sel_flag || sel_en) begin
      for (int b = 0; b < VEC_PER_WORD; b++) begin
        v = int'(widx) * VEC_PER_WORD + b;
        if (v < NUM_VEC) begin
          rd_word[b] = sel_flag ? flag_reg[v] : enable_reg[v];
        end
      end
    end else if (sel_lvl) begin
      for (int j = 0; j < VEC_PER_LVL; j++) begin
        v = int'(widx) * VEC_PER_LVL + j;
        if (v < NUM_VEC) begin
          rd_word[j*LVL_STRIDE +: 3] = level_reg[v];
        end
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  // APB: data and answer are captured in the setup cycle, so every access
  // completes with no wait state.
  assign wr_en = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= WORD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? WORD_ZERO : rd_word;
      pready <= 1'b1;
      pslverr <= rd_err;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // External pins: three-stage synchroniser; a level counts once stages two
  // and three agree, which also rejects single-cycle glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= '0;
      ext_s2_reg <= '0;
      ext_s3_reg <= '0;
      ext_level_reg <= '0;
    end else begin
      ext_s1_reg <= ext_int_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      for (int i = 0; i < NUM_EXT; i++) begin
        if (ext_s2_reg[i] == ext_s3_reg[i]) begin
          ext_level_reg[i] <= ext_s3_reg[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_EXT; i++) begin
      // Polarity 1 takes a falling edge, 0 a rising edge.
      ext_event[i] = (ext_s2_reg[i] == ext_s3_reg[i]) &&
                     (ext_s3_reg[i] != ext_level_reg[i]) &&
                     (ext_s3_reg[i] != edge_pol_reg[i]);
    end
  end

  // Timed-disable status comes from core logic on another timing path; two
  // stages keep it clean for the read mux and the priority gate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdis_s1_reg <= 1'b0;
      tdis_s2_reg <= 1'b0;
    end else begin
      tdis_s1_reg <= timed_disable_in;
      tdis_s2_reg <= tdis_s1_reg;
    end
  end

  // Request flags: a write stores the written bit, a same-cycle event ORs in.
  // The OR lets a set beat a clear on the same edge, so no request is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= '0;
    end else begin
      for (int k = 0; k < NUM_VEC; k++) begin
        flag_reg[k] <= ((wr_en && sel_flag && (int'(widx) == k / VEC_PER_WORD)) ?
                        pwdata[k % VEC_PER_WORD] : flag_reg[k]) |
                       periph_irq[k] |
                       ((k < NUM_EXT) ? ext_event[k % NUM_EXT] : 1'b0);
      end
    end
  end

  // Source enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= '0;
    end else if (wr_en && sel_en) begin
      for (int k = 0; k < NUM_VEC; k++) begin
        if (int'(widx) == k / VEC_PER_WORD) begin
          enable_reg[k] <= pwdata[k % VEC_PER_WORD];
        end
      end
    end
  end

  // Source levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_VEC; k++) begin
        level_reg[k] <= LEVEL_RESET;
      end
    end else if (wr_en && sel_lvl) begin
      for (int k = 0; k < NUM_VEC; k++) begin
        if (int'(widx) == k / VEC_PER_LVL) begin
          level_reg[k] <= pwdata[(k % VEC_PER_LVL) * LVL_STRIDE +: 3];
        end
      end
    end
  end

  // CPU level: interrupt entry and return outrank a software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_level_reg <= LEVEL_OFF;
    end else if (core_ack && irq_req) begin
      cpu_level_reg <= nest_disable_reg ? LEVEL_TOP : irq_level;
    end else if (core_return) begin
      cpu_level_reg <= core_return_level[2:0];
    end else if (wr_en && sel_sr && !nest_disable_reg) begin
      cpu_level_reg <= pwdata[CPU_LVL_LSB +: 3];
    end
  end

  // Top level bit: set by trap entry or loaded from core_return_level[3] on return, software may only clear it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_msb_reg <= 1'b0;
    end else if (core_trap_enter) begin
      level_msb_reg <= 1'b1;
    end else if (core_return) begin
      level_msb_reg <= core_return_level[3];
    end else if (wr_en && sel_core && !pwdata[LEVEL_MSB_BIT]) begin
      level_msb_reg <= 1'b0;
    end
  end

  // Global control 1: nesting control and sticky trap flags.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nest_disable_reg <= 1'b0;
      ovf_flag_reg <= 1'b0;
      addr_err_flag_reg <= 1'b0;
      stk_err_flag_reg <= 1'b0;
      osc_fail_flag_reg <= 1'b0;
    end else begin
      if (wr_en && sel_gc1) begin
        nest_disable_reg <= pwdata[NEST_DIS_BIT];
      end
      ovf_flag_reg <= ((wr_en && sel_gc1) ? pwdata[OVF_BIT] : ovf_flag_reg) |
                      trap_overflow;
      addr_err_flag_reg <= ((wr_en && sel_gc1) ? pwdata[ADDR_ERR_BIT] : addr_err_flag_reg) |
                           trap_addr_err;
      stk_err_flag_reg <= ((wr_en && sel_gc1) ? pwdata[STK_ERR_BIT] : stk_err_flag_reg) |
                          trap_stack_err;
      osc_fail_flag_reg <= ((wr_en && sel_gc1) ? pwdata[OSC_FAIL_BIT] : osc_fail_flag_reg) |
                           trap_osc_fail;
    end
  end

  // Global control 2: vector table select and edge polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_vector_sel <= 1'b0;
      edge_pol_reg <= '0;
    end else if (wr_en && sel_gc2) begin
      alt_vector_sel <= pwdata[ALT_VEC_BIT];
      edge_pol_reg <= pwdata[EDGE_POL_LSB +: NUM_EXT];
    end
  end

  // Priority search: strictly greater keeps the lowest vector on ties, and
  // level 0 can never win. Timed disable holds back levels below 7.
  always_comb begin
    best_lvl = LEVEL_OFF;
    best_vec = 7'h00;
    best_found = 1'b0;
    for (int k = 0; k < NUM_VEC; k++) begin
      if (flag_reg[k] && enable_reg[k] && (level_reg[k] > best_lvl) &&
          (!tdis_s2_reg || level_reg[k] == LEVEL_TOP)) begin
        best_lvl = level_reg[k];
        best_vec = 7'(k);
        best_found = 1'b1;
      end
    end
  end

  // Registered decision towards the core.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= 7'h00;
      irq_level <= LEVEL_OFF;
      cpu_level_out <= 4'h0;
    end else begin
      irq_req <= best_found &&
                 ({1'b0, best_lvl} > {level_msb_reg, cpu_level_reg});
      irq_vector <= best_vec;
      irq_level <= best_lvl;
      cpu_level_out <= {level_msb_reg, cpu_level_reg};
    end
  end

endmodule // icsr_regs

// File: rtl/icsr_pkg.sv
// Constants shared by the interrupt control and status register block.
package icsr_pkg;
  // Sources and register counts.
  localparam int NUM_VEC = 118;
  localparam int NUM_EXT = 5;
  localparam int NUM_FLAG_REGS = 8;
  localparam int NUM_LVL_REGS = 30;
  localparam int VEC_PER_WORD = 16;
  localparam int VEC_PER_LVL = 4;
  localparam int LVL_STRIDE = 4;
  // APB byte addresses of the registers.
  localparam logic [11:0] ADDR_CPU_STATUS = 12'h000;
  localparam logic [11:0] ADDR_CORE_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_GCTRL1 = 12'h008;
  localparam logic [11:0] ADDR_GCTRL2 = 12'h00c;
  localparam logic [11:0] ADDR_FLAG_BASE = 12'h040;
  localparam logic [11:0] ADDR_ENABLE_BASE = 12'h080;
  localparam logic [11:0] ADDR_LEVEL_BASE = 12'h100;
  // Field positions.
  localparam int CPU_LVL_LSB = 5;
  localparam int LEVEL_MSB_BIT = 3;
  localparam int NEST_DIS_BIT = 15;
  localparam int OVF_BIT = 4;
  localparam int ADDR_ERR_BIT = 3;
  localparam int STK_ERR_BIT = 2;
  localparam int OSC_FAIL_BIT = 1;
  localparam int ALT_VEC_BIT = 15;
  localparam int TIMED_DIS_BIT = 14;
  localparam int EDGE_POL_LSB = 0;
  // Level values and reset values.
  localparam logic [2:0] LEVEL_TOP = 3'h7;
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// File: sim/icsr_monitor.sv
// Checker of the APB answer and the interrupt request outputs.
`timescale 1ns/1ps
module icsr_monitor
  import icsr_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side.
  input wire logic core_ack,
  input wire logic core_trap_enter,
  input wire logic core_return,
  input wire logic irq_req,
  input wire logic [2:0] irq_level,
  input wire logic alt_vector_sel,
  input wire logic [3:0] cpu_level_out
);
  logic ctrl2_wr;
  assign ctrl2_wr = psel && penable && pready && pwrite && (paddr == ADDR_GCTRL2);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take;
    irq_req && core_ack;
  endsequence
  // The level may land one or two edges after the acknowledge.
  sequence s_level_set;
    (cpu_level_out[2:0] == $past(irq_level) || cpu_level_out[2:0] == LEVEL_TOP)
    or ##1 (cpu_level_out[2:0] == $past(irq_level, 2) || cpu_level_out[2:0] == LEVEL_TOP);
  endsequence
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_err_zero;
    pslverr && !pwrite |-> pready && prdata == WORD_ZERO;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  property p_upper_zero;
    pready && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_level_nonzero;
    irq_req |-> irq_level != LEVEL_OFF;
  endproperty
  a_level_nonzero: assert property (p_level_nonzero) else $error("level 0 request");
  property p_top_blocks;
    (cpu_level_out[2:0] == LEVEL_TOP) [*3] |-> !irq_req;
  endproperty
  a_top_blocks: assert property (p_top_blocks) else $error("request at level 7");
  property p_trap_blocks;
    (cpu_level_out[3]) [*3] |-> !irq_req;
  endproperty
  a_trap_blocks: assert property (p_trap_blocks) else $error("request in trap range");
  property p_msb_cause;
    $rose(cpu_level_out[3]) |-> $past(core_trap_enter) || $past(core_trap_enter, 2)
      || $past(core_return) || $past(core_return, 2);
  endproperty
  a_msb_cause: assert property (p_msb_cause) else $error("level msb set by software");
  property p_alt_cause;
    $changed(alt_vector_sel) |-> $past(ctrl2_wr);
  endproperty
  a_alt_cause: assert property (p_alt_cause) else $error("alt select moved alone");
  property p_ack_level;
    s_take |=> s_level_set;
  endproperty
  a_ack_level: assert property (p_ack_level) else $error("level not taken on ack");
endmodule // icsr_monitor

// File: sim/icsr_core_model.sv
// Behavioural processor core that takes interrupt requests.
`timescale 1ns/1ps
module icsr_core_model #(
  parameter int ACK_DELAY = 2
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request side.
  input wire logic irq_req,
  input wire logic [6:0] irq_vector,
  input wire logic take_en,
  // Acknowledge and record.
  output logic core_ack,
  output logic [6:0] taken_vec
);
  int wait_cnt;
  logic busy;
  // Waiting for the request to drop keeps one request from being taken twice.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'b0;
      busy <= 1'b0;
      taken_vec <= 7'h00;
      wait_cnt <= 0;
    end else begin
      core_ack <= 1'b0;
      if (busy) begin
        busy <= irq_req;
        wait_cnt <= 0;
      end else if (irq_req && take_en) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == ACK_DELAY) begin
          core_ack <= 1'b1;
          busy <= 1'b1;
          taken_vec <= irq_vector;
        end
      end else begin
        wait_cnt <= 0;
      end
    end
  end
endmodule // icsr_core_model

// File: sim/tb_top.sv
// Self-checking bench for the interrupt control and status registers.
`timescale 1ns/1ps
module tb_top;
  import icsr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, qe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [NUM_VEC-1:0] periph_irq = '0;
  logic [NUM_EXT-1:0] ext_int_pin = 5'h00;
  logic trap_overflow = 0, trap_addr_err = 0, trap_stack_err = 0, trap_osc_fail = 0;
  logic core_ack, core_trap_enter = 0, core_return = 0, timed_disable_in = 0, take_en = 0;
  logic [3:0] core_return_level = 4'h0, cpu_level_out;
  logic irq_req, alt_vector_sel;
  logic [6:0] irq_vector, taken_vec;
  logic [2:0] irq_level;
  int failures = 0, checks = 0;
  always #10 pclk = ~pclk;
  icsr_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph_irq(periph_irq), .ext_int_pin(ext_int_pin), .trap_overflow(trap_overflow),
    .trap_addr_err(trap_addr_err), .trap_stack_err(trap_stack_err),
    .trap_osc_fail(trap_osc_fail), .core_ack(core_ack), .core_trap_enter(core_trap_enter),
    .core_return(core_return), .core_return_level(core_return_level),
    .timed_disable_in(timed_disable_in), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .alt_vector_sel(alt_vector_sel), .cpu_level_out(cpu_level_out)
  );
  icsr_core_model #(.ACK_DELAY(1)) u_core (
    .pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector),
    .take_en(take_en), .core_ack(core_ack), .taken_vec(taken_vec)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  // One idle cycle after each transfer keeps the strobes from being driven twice at one edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
    end while (pready !== 1'b1);
    q = prdata;
    qe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    tick(16);
    presetn <= 1'b1;
    tick(1);
    rd("status", ADDR_CPU_STATUS, 32'h0);
    rd("ctrl2", ADDR_GCTRL2, 32'h0);
    rd("level0", ADDR_LEVEL_BASE, 32'h4444);
    rd("level29", ADDR_LEVEL_BASE + 12'h074, 32'h0044);
    rd("unmapped", 12'h200, 32'h0);
    chk("slverr", qe, 1'b1);
    apb(1'b1, ADDR_FLAG_BASE + 12'h002, 32'hffff);
    rd("misaligned", ADDR_FLAG_BASE, 32'h0);
    apb(1'b1, ADDR_FLAG_BASE + 12'h01c, 32'hffff);
    rd("flag7", ADDR_FLAG_BASE + 12'h01c, 32'h003f);
    apb(1'b1, ADDR_FLAG_BASE + 12'h01c, 32'h0);
    periph_irq[37] <= 1'b1;
    tick(1);
    periph_irq[37] <= 1'b0;
    periph_irq[20] <= 1'b1;
    tick(1);
    periph_irq[20] <= 1'b0;
    rd("flag2", ADDR_FLAG_BASE + 12'h008, 32'h0020);
    chk("req off", irq_req, 1'b0);
    apb(1'b1, ADDR_ENABLE_BASE + 12'h008, 32'h0020);
    tick(3);
    chk("req", irq_req, 1'b1);
    chk("vec", irq_vector, 7'h25);
    chk("lvl", irq_level, 3'h4);
    apb(1'b1, ADDR_ENABLE_BASE + 12'h004, 32'h0010);
    tick(3);
    chk("tie vec", irq_vector, 7'h14);
    apb(1'b1, ADDR_CPU_STATUS, 32'h0080);
    tick(3);
    chk("equal lvl", irq_req, 1'b0);
    chk("cpu lvl", cpu_level_out, 4'h4);
    apb(1'b1, ADDR_LEVEL_BASE + 12'h024, 32'h4454);
    tick(3);
    chk("higher vec", irq_vector, 7'h25);
    apb(1'b1, ADDR_LEVEL_BASE + 12'h024, 32'h4404);
    apb(1'b1, ADDR_LEVEL_BASE + 12'h014, 32'h4440);
    tick(3);
    chk("off lvl", irq_req, 1'b0);
    apb(1'b1, ADDR_LEVEL_BASE + 12'h024, 32'h4474);
    apb(1'b1, ADDR_CPU_STATUS, 32'h00e0);
    tick(3);
    chk("top lvl", irq_req, 1'b0);
    apb(1'b1, ADDR_GCTRL1, 32'h8000);
    rd("ctrl1", ADDR_GCTRL1, 32'h8000);
    apb(1'b1, ADDR_CPU_STATUS, 32'h0);
    rd("status ro", ADDR_CPU_STATUS, 32'h00e0);
    core_return <= 1'b1;
    tick(1);
    core_return <= 1'b0;
    take_en <= 1'b1;
    tick(8);
    take_en <= 1'b0;
    chk("nest lvl", cpu_level_out, 4'h7);
    chk("taken", taken_vec, 7'h25);
    apb(1'b1, ADDR_GCTRL1, 32'h0);
    core_trap_enter <= 1'b1;
    tick(1);
    core_trap_enter <= 1'b0;
    apb(1'b1, ADDR_CPU_STATUS, 32'h0);
    tick(3);
    chk("trap req", irq_req, 1'b0);
    rd("core", ADDR_CORE_CONTROL, 32'h0008);
    apb(1'b1, ADDR_CORE_CONTROL, 32'h0);
    rd("core clr", ADDR_CORE_CONTROL, 32'h0);
    tick(3);
    chk("req back", irq_req, 1'b1);
    {trap_overflow, trap_addr_err, trap_stack_err, trap_osc_fail} <= 4'hf;
    tick(1);
    {trap_overflow, trap_addr_err, trap_stack_err, trap_osc_fail} <= 4'h0;
    rd("traps", ADDR_GCTRL1, 32'h001e);
    apb(1'b1, ADDR_GCTRL1, 32'h0);
    rd("traps clr", ADDR_GCTRL1, 32'h0);
    timed_disable_in <= 1'b1;
    apb(1'b1, ADDR_GCTRL2, 32'h8015);
    rd("ctrl2 set", ADDR_GCTRL2, 32'hc015);
    chk("alt", alt_vector_sel, 1'b1);
    ext_int_pin <= 5'h1f;
    tick(8);
    rd("rise", ADDR_FLAG_BASE, 32'h000a);
    ext_int_pin <= 5'h00;
    tick(8);
    rd("fall", ADDR_FLAG_BASE, 32'h001f);
    timed_disable_in <= 1'b0;
    apb(1'b1, ADDR_GCTRL2, 32'h4000);
    tick(3);
    rd("ctrl2 ro", ADDR_GCTRL2, 32'h0);
    // Software clears flag 37 on the very edge at which its source pulses.
    fork
      apb(1'b1, ADDR_FLAG_BASE + 12'h008, 32'h0);
      begin
        tick(1);
        periph_irq[37] <= 1'b1;
        tick(1);
        periph_irq[37] <= 1'b0;
      end
    join
    rd("set wins", ADDR_FLAG_BASE + 12'h008, 32'h0020);
    stop_test();
  end
endmodule // tb_top
bind icsr_regs icsr_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_ack(core_ack),
  .core_trap_enter(core_trap_enter), .core_return(core_return), .irq_req(irq_req),
  .irq_level(irq_level), .alt_vector_sel(alt_vector_sel), .cpu_level_out(cpu_level_out)
);
